// *** hw/dbdc_pkg.sv ***
// Constants and types for the dual block DRAM controller.
// Functional notes
// - Sync-mode bit 0 selects async page/EDO, 1 selects synchronous SDRAM.
// - One mode bit serves both blocks; no per-block mode.
// - Both blocks refresh together at a rate set by refresh_count.
// - Refresh counter times intervals, then requests a refresh cycle.
// - Hit logic checks every bus cycle against both blocks' settings.
// - Page-hit logic flags async-mode accesses to the last page while it stays open.
// - Row and column addresses share one set of address pins.
// - Drive row, column, write strobes and mux; end cycle per mode.
// - Registers at 0x100, 0x108, 0x10c, 0x110, 0x114; 0x104 reserved.
// - External masters may read and write these registers.
// - Mask bits 6 to 1: 0 lets the access type hit, 1 blocks it.
// - Mask bits: CPU space, alt master, sup/user code and data.
// - Mask bit 0 is a valid flag, cleared at reset, gating decode.
// - One multiplexing scheme in both modes.
// - Row phase: pins 9 to 19 carry address bits 9 to 19.
// - Column: pins 15..9 carry bits 2..8; pin 17 bit 16 on 32-bit ports.
// - Column: pin 17 bit 0 for 8-bit, pin 16 bit 1 for 8/16-bit ports.
// - Pin 18 carries bit 17 for 16-bit, or 32-bit with eight column lines.
// - Pin 19 carries bit 18 only for 16-bit ports with nine or more columns.
package dbdc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [8:0] OFS_CTRL = 9'h100;
  localparam logic [8:0] OFS_RSVD = 9'h104;
  localparam logic [8:0] OFS_ADDR0 = 9'h108;
  localparam logic [8:0] OFS_MASK0 = 9'h10c;
  localparam logic [8:0] OFS_ADDR1 = 9'h110;
  localparam logic [8:0] OFS_MASK1 = 9'h114;
  // ==========================================================
  // Control register fields, upper half of the word
  localparam int CTRL_SYNC_BIT = 31;
  localparam int REFRESH_MSB = 26;
  localparam int REFRESH_LSB = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ==========================================================
  // Address/control register fields
  localparam int BASE_MSB = 31;
  localparam int BASE_LSB = 18;
  localparam int COLS_MSB = 9;
  localparam int COLS_LSB = 8;
  localparam int PS_MSB = 5;
  localparam int PS_LSB = 4;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int VALID_BIT = 0;
  // Mask bit positions per access type.
  localparam int TYPE_CPU = 6;
  localparam int TYPE_ALT = 5;
  localparam int TYPE_SUP_CODE = 4;
  localparam int TYPE_SUP_DATA = 3;
  localparam int TYPE_USR_CODE = 2;
  localparam int TYPE_USR_DATA = 1;
  // Port size codes.
  localparam logic [1:0] PS_32 = 2'h0;
  localparam logic [1:0] PS_8 = 2'h1;
  localparam logic [1:0] PS_16 = 2'h2;
  // Column line codes: 0 means eight columns.
  localparam logic [1:0] COLS_8 = 2'h0;
  // ==========================================================
  // Timing counts
  localparam int REFRESH_UNIT = 16;
  localparam logic [3:0] PHASE_CYCLES = 4'h2;
  // Page spans address bits above the column.
  localparam int PAGE_LSB = 9;
  // ==========================================================
  // Control states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ROW = 6'b000010,
    ST_COL = 6'b000100,
    ST_DONE = 6'b001000,
    ST_REF = 6'b010000,
    ST_PRE = 6'b100000
  } dbdc_state_e;
endpackage : dbdc_pkg

// *** hw/dbdc_refresh.sv ***
// Refresh interval counter for both DRAM blocks.
`timescale 1ns/100ps
module dbdc_refresh (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Control
  input wire logic [10:0] refresh_count_i,
  input wire logic refresh_ack_i,
  // Request
  output logic refresh_req_o
);
  import dbdc_pkg::*;
  logic [14:0] count;
  logic [14:0] limit;
  assign limit = {refresh_count_i, 4'h0} + 15'h000f;
  // Counts (refresh_count + 1) * 16 cycles per interval.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      count <= 15'h0000;
    end else if (count >= limit) begin
      count <= 15'h0000;
    end else begin
      count <= count + 15'h0001;
    end
  end
  // Request holds until serviced; a new interval wins over the ack.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      refresh_req_o <= 1'b0;
    end else if (count >= limit) begin
      refresh_req_o <= 1'b1;
    end else if (refresh_ack_i) begin
      refresh_req_o <= 1'b0;
    end
  end
endmodule : dbdc_refresh

// *** hw/dbdc_ctrl.sv ***
// Dual block DRAM controller: registers, hit, page and strobe logic.
`timescale 1ns/100ps
module dbdc_ctrl (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Register access from any master
  input wire logic REG_SEL_I,
  input wire logic REG_WR_I,
  input wire logic [8:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_ACK_O,
  // Memory bus cycle
  input wire logic MEM_REQ_I,
  input wire logic MEM_WR_I,
  input wire logic [31:0] MEM_ADDR_I,
  input wire logic MEM_CPU_SPACE_I,
  input wire logic MEM_ALT_MASTER_I,
  input wire logic MEM_SUPER_I,
  input wire logic MEM_CODE_I,
  output logic MEM_ACK_O,
  output logic MEM_PAGE_HIT_O,
  // DRAM pins
  output logic [19:9] DRAM_ADDR_O,
  output logic [1:0] DRAM_ROW_N_O,
  output logic DRAM_COL_N_O,
  output logic DRAM_WRITE_N_O,
  output logic DRAM_SYNC_O
);
  import dbdc_pkg::*;
  // ==========================================================
  // Registers
  logic [15:0] ctrl;
  logic [31:0] addr_ctl [2];
  logic [31:0] mask [2];
  logic [10:0] refresh_count;
  logic sync_mode;
  logic refresh_req;
  logic refresh_ack;
  assign refresh_count = ctrl[REFRESH_MSB-16:REFRESH_LSB-16];
  assign sync_mode = ctrl[CTRL_SYNC_BIT-16];

  // Writes accepted from on-chip or external masters alike.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ctrl <= CTRL_RESET;
      addr_ctl[0] <= ADDR_RESET;
      addr_ctl[1] <= ADDR_RESET;
      mask[0] <= MASK_RESET;
      mask[1] <= MASK_RESET;
    end else if (REG_SEL_I && REG_WR_I) begin
      case (REG_ADDR_I)
        OFS_CTRL: ctrl <= REG_WDATA_I[31:16];
        OFS_ADDR0: addr_ctl[0] <= REG_WDATA_I;
        OFS_MASK0: mask[0] <= REG_WDATA_I;
        OFS_ADDR1: addr_ctl[1] <= REG_WDATA_I;
        OFS_MASK1: mask[1] <= REG_WDATA_I;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Read data and acknowledge; reserved words read zero.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 32'h0000_0000;
      REG_ACK_O <= 1'b0;
    end else begin
      REG_ACK_O <= REG_SEL_I && !REG_ACK_O;
      case (REG_ADDR_I)
        OFS_CTRL: REG_RDATA_O <= {ctrl, 16'h0000};
        OFS_RSVD: REG_RDATA_O <= 32'h0000_0000;
        OFS_ADDR0: REG_RDATA_O <= addr_ctl[0];
        OFS_MASK0: REG_RDATA_O <= mask[0];
        OFS_ADDR1: REG_RDATA_O <= addr_ctl[1];
        OFS_MASK1: REG_RDATA_O <= mask[1];
        default: REG_RDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Hit logic
  function automatic logic [6:1] type_bits(input logic cpu,
      input logic alt, input logic sup, input logic code);
    logic [6:1] t;
    t = 6'h00;
    t[TYPE_CPU] = cpu;
    t[TYPE_ALT] = alt;
    t[TYPE_SUP_CODE] = !cpu && !alt && sup && code;
    t[TYPE_SUP_DATA] = !cpu && !alt && sup && !code;
    t[TYPE_USR_CODE] = !cpu && !alt && !sup && code;
    t[TYPE_USR_DATA] = !cpu && !alt && !sup && !code;
    return t;
  endfunction : type_bits

  logic [6:1] acc_type;
  logic [1:0] hit;
  assign acc_type = type_bits(MEM_CPU_SPACE_I, MEM_ALT_MASTER_I,
                              MEM_SUPER_I, MEM_CODE_I);
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_hit
      logic [BASE_MSB:BASE_LSB] amask;
      assign amask = ~mask[b][BASE_MSB:BASE_LSB];
      assign hit[b] = mask[b][VALID_BIT]
        && (((MEM_ADDR_I[BASE_MSB:BASE_LSB]
              ^ addr_ctl[b][BASE_MSB:BASE_LSB]) & amask) == '0)
        && ((acc_type & mask[b][6:1]) == 6'h00);
    end
  endgenerate

  // ==========================================================
  // Access latch, page tracking
  logic [31:0] cur_addr;
  logic cur_wr;
  logic cur_blk;
  logic [31:PAGE_LSB] last_page;
  logic last_blk;
  logic page_open;
  logic page_hit;
  logic [1:0] cur_ps;
  logic [1:0] cur_cols;
  logic [31:0] acc_addr;
  logic acc_blk;
  logic acc_wr;
  assign page_hit = page_open && (last_blk == hit[1])
                    && (last_page == MEM_ADDR_I[31:PAGE_LSB]);
  assign cur_ps = addr_ctl[acc_blk][PS_MSB:PS_LSB];
  assign cur_cols = addr_ctl[acc_blk][COLS_MSB:COLS_LSB];

  // ==========================================================
  // Address multiplexing, one scheme for both modes
  function automatic logic [19:9] col_addr(input logic [31:0] a,
      input logic [1:0] ps, input logic [1:0] cols);
    logic [19:9] p;
    p = 11'h000;
    p[15:9] = {a[2], a[3], a[4], a[5], a[6], a[7], a[8]};
    if (ps == PS_8) begin
      p[17] = a[0];
    end else if (ps == PS_32) begin
      p[17] = a[16];
    end
    if (ps == PS_8 || ps == PS_16) begin
      p[16] = a[1];
    end
    if (ps == PS_16 || (ps == PS_32 && cols == COLS_8)) begin
      p[18] = a[17];
    end
    if (ps == PS_16 && cols != COLS_8) begin
      p[19] = a[18];
    end
    return p;
  endfunction : col_addr

  // ==========================================================
  // Control state machine
  dbdc_state_e state;
  dbdc_state_e next_state;
  logic [3:0] wait_cnt;
  logic phase_done;
  logic start;
  assign phase_done = (wait_cnt == PHASE_CYCLES);
  assign start = MEM_REQ_I && (hit != 2'b00) && !MEM_ACK_O;
  assign refresh_ack = (state == ST_REF) && phase_done;
  // The first strobe cycle is launched from the bus, not the stale latch.
  assign acc_addr = (state == ST_IDLE) ? MEM_ADDR_I : cur_addr;
  assign acc_blk = (state == ST_IDLE) ? hit[1] : cur_blk;
  assign acc_wr = (state == ST_IDLE) ? MEM_WR_I : cur_wr;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (refresh_req) begin
          next_state = ST_PRE;
        end else if (start && page_hit && !sync_mode) begin
          next_state = ST_COL;
        end else if (start) begin
          next_state = page_open ? ST_PRE : ST_ROW;
        end
      end
      ST_PRE: begin
        if (phase_done) begin
          next_state = refresh_req ? ST_REF : ST_ROW;
        end
      end
      ST_ROW: if (phase_done) next_state = ST_COL;
      ST_COL: if (phase_done) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      ST_REF: if (phase_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state <= ST_IDLE;
      wait_cnt <= 4'h0;
    end else begin
      state <= next_state;
      wait_cnt <= (next_state != state) ? 4'h0 : wait_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      cur_addr <= 32'h0000_0000;
      cur_wr <= 1'b0;
      cur_blk <= 1'b0;
      last_page <= '0;
      last_blk <= 1'b0;
      page_open <= 1'b0;
      MEM_PAGE_HIT_O <= 1'b0;
    end else if (state == ST_IDLE && start && !refresh_req) begin
      cur_addr <= MEM_ADDR_I;
      cur_wr <= MEM_WR_I;
      cur_blk <= hit[1];
      last_page <= MEM_ADDR_I[31:PAGE_LSB];
      last_blk <= hit[1];
      page_open <= !sync_mode;
      MEM_PAGE_HIT_O <= page_hit;
    end else if (state == ST_REF) begin
      page_open <= 1'b0;
    end
  end

  // Pins: row phase then column phase, strobes per state.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      DRAM_ADDR_O <= 11'h000;
      DRAM_ROW_N_O <= 2'b11;
      DRAM_COL_N_O <= 1'b1;
      DRAM_WRITE_N_O <= 1'b1;
      MEM_ACK_O <= 1'b0;
      DRAM_SYNC_O <= 1'b0;
    end else begin
      DRAM_SYNC_O <= sync_mode;
      MEM_ACK_O <= (next_state == ST_DONE);
      case (next_state)
        ST_ROW: begin
          DRAM_ADDR_O <= acc_addr[19:9];
          DRAM_ROW_N_O <= acc_blk ? 2'b01 : 2'b10;
          DRAM_COL_N_O <= 1'b1;
        end
        ST_COL: begin
          DRAM_ADDR_O <= col_addr(acc_addr, cur_ps, cur_cols);
          DRAM_ROW_N_O <= acc_blk ? 2'b01 : 2'b10;
          DRAM_COL_N_O <= 1'b0;
          DRAM_WRITE_N_O <= !acc_wr;
        end
        ST_REF: begin
          DRAM_ROW_N_O <= 2'b00;
          DRAM_COL_N_O <= 1'b0;
          DRAM_WRITE_N_O <= 1'b1;
        end
        ST_DONE: begin
          DRAM_COL_N_O <= 1'b1;
          DRAM_WRITE_N_O <= 1'b1;
          if (sync_mode) DRAM_ROW_N_O <= 2'b11;
        end
        ST_PRE: begin
          DRAM_ROW_N_O <= 2'b11;
          DRAM_COL_N_O <= 1'b1;
          DRAM_WRITE_N_O <= 1'b1;
        end
        default: begin
          DRAM_COL_N_O <= 1'b1;
          DRAM_WRITE_N_O <= 1'b1;
          if (!page_open) DRAM_ROW_N_O <= 2'b11;
        end
      endcase
    end
  end

  // ==========================================================
  // Refresh counter
  dbdc_refresh u_refresh (
    .CLK_I(CLK_I),
    .RESETN_I(RESETN_I),
    .refresh_count_i(refresh_count),
    .refresh_ack_i(refresh_ack),
    .refresh_req_o(refresh_req)
  );
endmodule : dbdc_ctrl

// *** tb/dbdc_monitor.sv ***
// Port checks for the DRAM controller.
`timescale 1ns/100ps
module dbdc_monitor (
  // Watched ports
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic REG_SEL_I,
  input wire logic REG_WR_I,
  input wire logic [8:0] REG_ADDR_I,
  input wire logic REG_ACK_O,
  input wire logic MEM_REQ_I,
  input wire logic [31:0] MEM_ADDR_I,
  input wire logic MEM_WR_I,
  input wire logic MEM_ACK_O,
  input wire logic DRAM_WRITE_N_O,
  input wire logic [19:9] DRAM_ADDR_O,
  input wire logic [1:0] DRAM_ROW_N_O,
  input wire logic DRAM_COL_N_O,
  input wire logic DRAM_SYNC_O
);
  logic ctrl_wr;
  assign ctrl_wr = REG_SEL_I && REG_WR_I && REG_ADDR_I == 9'h100;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  sequence s_row_start;
    $past(DRAM_ROW_N_O) == 2'b11 && ^DRAM_ROW_N_O;
  endsequence
  sequence s_col_start;
    $fell(DRAM_COL_N_O) && ^DRAM_ROW_N_O;
  endsequence
  property p_reg_ack;
    REG_SEL_I && !REG_ACK_O |=> REG_ACK_O;
  endproperty
  property p_reg_pulse;
    REG_ACK_O |=> !REG_ACK_O;
  endproperty
  property p_mem_pulse;
    MEM_ACK_O |=> !MEM_ACK_O;
  endproperty
  property p_mem_cause;
    MEM_ACK_O |-> $past(MEM_REQ_I) && $past(MEM_REQ_I, 2);
  endproperty
  property p_reset_idle;
    $rose(RESETN_I) |-> DRAM_ROW_N_O == 2'b11 && DRAM_COL_N_O && !MEM_ACK_O;
  endproperty
  property p_sync_mode;
    $changed(DRAM_SYNC_O) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  property p_row_mux;
    s_row_start |-> DRAM_ADDR_O == MEM_ADDR_I[19:9];
  endproperty
  property p_col_mux;
    s_col_start |-> DRAM_ADDR_O[15:9] == {MEM_ADDR_I[2], MEM_ADDR_I[3],
      MEM_ADDR_I[4], MEM_ADDR_I[5], MEM_ADDR_I[6], MEM_ADDR_I[7],
      MEM_ADDR_I[8]};
  endproperty
  property p_write_strobe;
    s_col_start |-> DRAM_WRITE_N_O == !MEM_WR_I;
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register ack missing");
  a_reg_pulse: assert property (p_reg_pulse)
    else $error("register ack too long");
  a_mem_pulse: assert property (p_mem_pulse)
    else $error("memory ack too long");
  a_mem_cause: assert property (p_mem_cause)
    else $error("memory ack without request");
  a_reset_idle: assert property (p_reset_idle)
    else $error("strobes active after reset");
  a_sync_mode: assert property (p_sync_mode)
    else $error("mode changed without control write");
  a_row_mux: assert property (p_row_mux)
    else $error("row address wrong");
  a_col_mux: assert property (p_col_mux)
    else $error("column address wrong");
  a_write_strobe: assert property (p_write_strobe)
    else $error("write strobe wrong");
endmodule : dbdc_monitor
bind dbdc_ctrl dbdc_monitor dbdc_monitor_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .REG_SEL_I(REG_SEL_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_ACK_O(REG_ACK_O), .MEM_REQ_I(MEM_REQ_I), .MEM_ADDR_I(MEM_ADDR_I),
  .MEM_WR_I(MEM_WR_I), .DRAM_WRITE_N_O(DRAM_WRITE_N_O),
  .MEM_ACK_O(MEM_ACK_O), .DRAM_ADDR_O(DRAM_ADDR_O),
  .DRAM_ROW_N_O(DRAM_ROW_N_O), .DRAM_COL_N_O(DRAM_COL_N_O),
  .DRAM_SYNC_O(DRAM_SYNC_O));

// *** tb/dbdc_dram_model.sv ***
// Behavioural DRAM that logs strobes and addresses.
`timescale 1ns/100ps
module dbdc_dram_model (
  // DRAM pins
  input wire logic CLK_I,
  input wire logic [19:9] addr_i,
  input wire logic [1:0] row_n_i,
  input wire logic col_n_i,
  input wire logic write_n_i,
  // Observations
  output logic [19:9] row_addr_o,
  output logic [19:9] col_addr_o,
  output logic [1:0] row_sel_o,
  output logic write_n_o,
  output int refresh_cnt_o = 0
);
  logic [1:0] prev_row = 2'b11;
  logic prev_col = 1'b1;
  always @(posedge CLK_I) begin
    if (prev_row == 2'b11 && ^row_n_i) begin
      row_addr_o <= addr_i;
      row_sel_o <= ~row_n_i;
    end
    if (prev_col && !col_n_i && ^row_n_i) begin
      col_addr_o <= addr_i;
      write_n_o <= write_n_i;
    end
    if (prev_row != 2'b00 && row_n_i == 2'b00) begin
      refresh_cnt_o <= refresh_cnt_o + 1;
    end
    prev_row <= row_n_i;
    prev_col <= col_n_i;
  end
endmodule : dbdc_dram_model

// *** tb/test_dual_block_dram_controller.sv ***
// Self-checking bench for the DRAM controller.
`timescale 1ns/100ps
module test_dual_block_dram_controller;
  import dbdc_pkg::*;
  logic CLK_I = 1'b0, RESETN_I = 1'b0, REG_SEL_I = 1'b0, REG_WR_I = 1'b0;
  logic [8:0] REG_ADDR_I = '0;
  logic [31:0] REG_WDATA_I = '0, MEM_ADDR_I = '0, REG_RDATA_O, rd;
  logic MEM_REQ_I = 1'b0, MEM_WR_I = 1'b0, REG_ACK_O, MEM_ACK_O, ok;
  logic [3:0] attr = '0;
  logic MEM_PAGE_HIT_O, DRAM_COL_N_O, DRAM_WRITE_N_O, DRAM_SYNC_O, wr_n;
  logic [19:9] DRAM_ADDR_O, row_addr, col_addr;
  logic [1:0] DRAM_ROW_N_O, row_sel;
  int n_mismatch = 0, num_checks = 0, cycles = 0, ref_cnt, n;
  logic [8:0] offs [6] = '{9'h100, 9'h104, 9'h108, 9'h10c, 9'h110, 9'h114};
  logic [31:0] vals [6] = '{32'h87ff_0000, 32'hffff_ffff, 32'hfffc_0330,
    32'hfffc_007f, 32'h0004_0000, 32'h0000_0000};
  logic [3:0] att [6] = '{4'b1000, 4'b0100, 4'b0011, 4'b0010, 4'b0001, 4'b0};
  int pa [4] = '{17, 17, 16, 19}, ba [4] = '{16, 0, 1, 18};
  int pb [4] = '{18, 16, 18, 16}, bb [4] = '{17, 1, 17, 1};
  logic [1:0] pst [4] = '{PS_32, PS_8, PS_16, PS_16};
  logic [31:0] adr [2] = '{32'h0005_a5a5, 32'h000a_5a5a};
  always #10 CLK_I = ~CLK_I;
  dbdc_ctrl dbdc_ctrl_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
    .REG_SEL_I(REG_SEL_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_ACK_O(REG_ACK_O), .MEM_REQ_I(MEM_REQ_I), .MEM_WR_I(MEM_WR_I),
    .MEM_ADDR_I(MEM_ADDR_I), .MEM_CPU_SPACE_I(attr[3]),
    .MEM_ALT_MASTER_I(attr[2]), .MEM_SUPER_I(attr[1]), .MEM_CODE_I(attr[0]),
    .MEM_ACK_O(MEM_ACK_O), .MEM_PAGE_HIT_O(MEM_PAGE_HIT_O),
    .DRAM_ADDR_O(DRAM_ADDR_O), .DRAM_ROW_N_O(DRAM_ROW_N_O),
    .DRAM_COL_N_O(DRAM_COL_N_O), .DRAM_WRITE_N_O(DRAM_WRITE_N_O),
    .DRAM_SYNC_O(DRAM_SYNC_O));
  dbdc_dram_model dbdc_dram_model_i (.CLK_I(CLK_I), .addr_i(DRAM_ADDR_O),
    .row_n_i(DRAM_ROW_N_O), .col_n_i(DRAM_COL_N_O),
    .write_n_i(DRAM_WRITE_N_O), .row_addr_o(row_addr),
    .col_addr_o(col_addr), .row_sel_o(row_sel), .write_n_o(wr_n),
    .refresh_cnt_o(ref_cnt));
  task final_report();
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task reg_acc(input logic wr, input logic [8:0] a, input logic [31:0] d);
    REG_SEL_I <= 1'b1;
    REG_WR_I <= wr;
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK_I);
      if (REG_ACK_O === 1'b1) break;
    end
    rd = REG_RDATA_O;
    REG_SEL_I <= 1'b0;
    @(posedge CLK_I);
  endtask : reg_acc
  task mem(input logic [31:0] a, input logic [3:0] t);
    MEM_REQ_I <= 1'b1;
    MEM_WR_I <= a[2];
    MEM_ADDR_I <= a;
    attr <= t;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(posedge CLK_I);
      ok = (MEM_ACK_O === 1'b1);
    end
    MEM_REQ_I <= 1'b0;
    @(posedge CLK_I);
  endtask : mem
  initial begin
    repeat (5) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    @(posedge CLK_I);
    for (int i = 0; i < 6; i++) begin
      reg_acc(0, offs[i], 0);
      chk("reset_value", 0, rd);
      reg_acc(1, offs[i], vals[i]);
      reg_acc(0, offs[i], 0);
      chk("readback", i == 1 ? 0 : vals[i], rd);
    end
    reg_acc(0, 9'h118, 0);
    chk("unmapped", 0, rd);
    chk("sync_on", 1, DRAM_SYNC_O);
    reg_acc(1, 9'h100, 32'h07ff_0000);
    chk("sync_off", 0, DRAM_SYNC_O);
    reg_acc(1, 9'h10c, 32'hfffc_0001);
    for (int c = 0; c < 4; c++) begin
      reg_acc(1, 9'h108, {26'h0, pst[c], 4'h0} | (c == 3 ? 32'h100 : 0));
      for (int k = 0; k < 2; k++) begin
        mem(adr[k], 4'b0);
        chk("hit", 1, ok);
        chk("row", adr[k][19:9], row_addr);
        chk("block", 2'b01, row_sel);
        chk("col_a", adr[k][ba[c]], col_addr[pa[c]]);
        chk("col_b", adr[k][bb[c]], col_addr[pb[c]]);
        chk("write_n", !adr[k][2], wr_n);
      end
    end
    mem(adr[1] + 4, 4'b0);
    chk("page_hit", 1, MEM_PAGE_HIT_O);
    mem(adr[0] ^ 32'h200, 4'b0);
    chk("page_miss", 0, MEM_PAGE_HIT_O);
    for (int i = 0; i < 6; i++) begin
      reg_acc(1, 9'h10c, 32'hfffc_0001 | (32'h1 << (6 - i)));
      mem(adr[0], att[i]);
      chk("masked", 0, ok);
      reg_acc(1, 9'h10c, 32'hfffc_007f ^ (32'h1 << (6 - i)));
      mem(adr[0], att[i]);
      chk("allowed", 1, ok);
    end
    reg_acc(1, 9'h10c, 32'h0);
    reg_acc(1, 9'h114, 32'h1);
    mem(32'h0004_0010, 4'b0);
    chk("blk1", 3, {ok, row_sel[1]});
    mem(32'h0000_0010, 4'b0);
    chk("base_miss", 0, ok);
    reg_acc(1, 9'h114, 32'h0);
    mem(32'h0004_0010, 4'b0);
    chk("invalid", 0, ok);
    reg_acc(1, 9'h114, 32'h1);
    reg_acc(1, 9'h100, 32'h87ff_0000);
    mem(32'h0004_0020, 4'b0);
    chk("sync_acc", 1, ok);
    reg_acc(1, 9'h100, 32'h0003_0000);
    n = ref_cnt;
    for (int i = 0; i < 33000 && ref_cnt == n; i++) @(posedge CLK_I);
    n = ref_cnt;
    repeat (640) @(posedge CLK_I);
    chk("refresh", 1, ref_cnt - n >= 9 && ref_cnt - n <= 11);
    mem(32'h0004_0030, 4'b0);
    chk("acc_refresh", 1, ok);
    final_report();
  end
endmodule : test_dual_block_dram_controller
